// *** secr_regs.sv ***
// extended switch configuration registers 12h..14h behind a serial management slave
// assumes the management master obeys mdc/mdio framing and that status inputs are on core_clk
`timescale 1ns/1ps
`default_nettype none

module secr_regs
  import secr_pkg::*;
#(
  parameter logic [4:0] SMI_PHY_ADDR = 5'h00,          // device address the bank answers on
  parameter int         CNT_W        = 8,              // broadcast queue count width
  parameter longint     AGING_CYCLES = secr_pkg::AGING_CYCLES_DFLT,
  parameter logic [7:0] STORM_THR0   = 8'h08,
  parameter logic [7:0] STORM_THR1   = 8'h10,
  parameter logic [7:0] STORM_THR2   = 8'h20,
  parameter logic [7:0] STORM_THR3   = 8'h40
) (
  input  wire logic                       core_clk,           // core clock
  input  wire logic                       sys_rst,            // synchronous reset
  input  wire logic                       mdcPin,             // smi clock pin
  input  wire logic                       mdioIn,             // smi data pin level
  output logic                            mdioOut,            // smi data drive value
  output logic                            mdioOeN,            // low while driving mdio
  input  wire logic [secr_pkg::REG_W-1:0] romWord12,          // eeprom/strap global word
  input  wire logic [secr_pkg::REG_W-1:0] romWord13,          // eeprom/strap port 0/1 word
  input  wire logic [secr_pkg::REG_W-1:0] romWord14,          // eeprom/strap port 2/3 word
  input  wire logic                       port4ExternalSelect,// expansion port replaces port 4
  input  wire logic                       expansionSpeedIn,   // expansion port is 100M
  input  wire logic                       expansionDuplexIn,  // expansion port is full duplex
  input  wire logic                       port4SpeedIn,       // port 4 is 100M
  input  wire logic                       port4DuplexIn,      // port 4 is full duplex
  input  wire logic [CNT_W-1:0]           bcastQueueCount,    // queued broadcast packets
  input  wire logic [1:0]                 stormThresholdSel,  // threshold selection
  input  wire logic                       pktArrive,          // packet arrival strobe
  input  wire logic [4:0]                 portFullDuplex,     // negotiated full duplex
  input  wire logic [4:0]                 partnerPause,       // partner supports pause
  input  wire logic [4:0]                 backpressureReq,    // congestion per port
  input  wire logic [3:0]                 rxTagHigh,          // frame tag says high priority
  output logic [1:0]                      ledMode,            // led display mode
  output logic                            pauseEnable,        // pause flow control on
  output logic                            backpressureEnable, // backpressure allowed
  output logic [4:0]                      backpressureApply,  // backpressure per port
  output logic                            expansionPortFlowEnable, // expansion flow ctl
  output logic                            configFromRegisters,// register set in use
  output logic                            duplexFallbackEnable,    // fallback allowed
  output logic [4:0]                      effFullDuplex,      // duplex after fallback
  output logic                            agingEnable,        // aging on
  output logic                            agingTick,          // aging period elapsed
  output logic                            stormDrop,          // drop the arriving packet
  output logic [3:0]                      framePriorityEn,    // per port frame priority
  output logic [3:0]                      portPriorityEn,     // per port port priority
  output logic [3:0]                      rxHighPriority      // packet goes to high queue
);

  if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt
    $error("CNT_W must be 1 to 8");
  end
  if (AGING_CYCLES < 1 || AGING_CYCLES >= (64'h1 << AGING_CNT_W)) begin : g_bad_aging
    $error("AGING_CYCLES out of counter range");
  end

  localparam logic [AGING_CNT_W-1:0] AGING_LAST = AGING_CNT_W'(AGING_CYCLES - 1);

  function automatic logic [7:0] stormLimit(input logic [1:0] sel);
    logic [7:0] thr;
    thr = STORM_THR0;
    if (sel == 2'h1) begin
      thr = STORM_THR1;
    end else if (sel == 2'h2) begin
      thr = STORM_THR2;
    end else if (sel == 2'h3) begin
      thr = STORM_THR3;
    end
    return thr;
  endfunction

  // pin synchronisation
  logic mdcRise;
  logic mdioBit;

  secr_pin_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .mdcPin   (mdcPin),
    .mdioPin  (mdioIn),
    .mdcRise  (mdcRise),
    .mdioSync (mdioBit)
  );

  // register storage
  logic [15:0] global_reg;
  logic [15:0] prio01_reg;
  logic [15:0] prio23_reg;

  // smi frame state
  secr_smi_state_e state_reg;
  secr_smi_state_e state_next;
  logic [4:0]      bitCnt_reg;
  logic [15:0]     rxShift_reg;
  logic [15:0]     txShift_reg;
  logic            opRead_reg;
  logic            opWrite_reg;
  logic            addrHit_reg;
  logic [4:0]      regAddr_reg;
  logic            mdioOut_reg;
  logic            mdioOeN_reg;

  // read-only status follows the selected port
  wire statSpeed  = port4ExternalSelect ? expansionSpeedIn : port4SpeedIn;
  wire statDuplex = port4ExternalSelect ? expansionDuplexIn : port4DuplexIn;

  // reserved positions are masked off on read as well as on write
  wire [15:0] globalRead = (global_reg & GLOBAL_WR_MASK)
                         | (16'(statSpeed) << SPEED_ST)
                         | (16'(statDuplex) << DUPLEX_ST);

  wire isGlobal = (regAddr_reg == REG_GLOBAL);
  wire isPrio01 = (regAddr_reg == REG_PRIO01);
  wire isPrio23 = (regAddr_reg == REG_PRIO23);
  wire [15:0] readData = isGlobal ? globalRead
                       : isPrio01 ? (prio01_reg & PRIO_WR_MASK)
                       : isPrio23 ? (prio23_reg & PRIO_WR_MASK)
                       : 16'h0000;

  wire [9:0]  addrWord  = {rxShift_reg[8:0], mdioBit};
  wire [15:0] writeWord = {rxShift_reg[14:0], mdioBit};
  wire        addrMatch = (addrWord[9:5] == SMI_PHY_ADDR)
                        && ((addrWord[4:0] == REG_GLOBAL)
                         || (addrWord[4:0] == REG_PRIO01)
                         || (addrWord[4:0] == REG_PRIO23));
  wire        opLast    = (bitCnt_reg == SMI_OP_LAST);
  wire        addrLast  = (bitCnt_reg == SMI_ADDR_LAST);
  wire        dataLast  = (bitCnt_reg == SMI_DATA_LAST);
  wire [1:0]  opCode    = {rxShift_reg[0], mdioBit};
  wire        respond   = opRead_reg & addrHit_reg;
  wire        commit    = mdcRise && (state_reg == ST_DATA) && dataLast
                          && opWrite_reg && addrHit_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!mdioBit) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        state_next = mdioBit ? ST_OP : ST_IDLE;
      end
      ST_OP: begin
        if (opLast) begin
          state_next = (opCode == SMI_OP_READ || opCode == SMI_OP_WRITE) ? ST_ADDR : ST_IDLE;
        end
      end
      ST_ADDR: begin
        if (addrLast) begin
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        if (bitCnt_reg == SMI_TA_LAST) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (dataLast) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire stateChange = (state_next != state_reg);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      bitCnt_reg  <= 5'h00;
      rxShift_reg <= 16'h0000;
    end else if (mdcRise) begin
      state_reg   <= state_next;
      bitCnt_reg  <= stateChange ? 5'h00 : 5'(bitCnt_reg + 5'h01);
      rxShift_reg <= {rxShift_reg[14:0], mdioBit};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opRead_reg  <= 1'b0;
      opWrite_reg <= 1'b0;
      addrHit_reg <= 1'b0;
      regAddr_reg <= 5'h00;
    end else if (mdcRise && state_reg == ST_OP && opLast) begin
      opRead_reg  <= (opCode == SMI_OP_READ);
      opWrite_reg <= (opCode == SMI_OP_WRITE);
    end else if (mdcRise && state_reg == ST_ADDR && addrLast) begin
      addrHit_reg <= addrMatch;
      regAddr_reg <= addrWord[4:0];
    end
  end

  // read data is snapshotted at the turnaround so a frame never shows a torn value;
  // output changes a few core cycles after mdc rises, well inside the mdc period
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txShift_reg <= 16'h0000;
      mdioOut_reg <= 1'b1;
      mdioOeN_reg <= 1'b1;
    end else if (mdcRise && state_reg == ST_TURN && bitCnt_reg == 5'h00) begin
      txShift_reg <= readData;
      mdioOut_reg <= 1'b0;
      mdioOeN_reg <= ~respond;
    end else if (mdcRise && state_reg == ST_TURN) begin
      txShift_reg <= {txShift_reg[14:0], 1'b0};
      mdioOut_reg <= txShift_reg[15];
    end else if (mdcRise && state_reg == ST_DATA && !dataLast) begin
      txShift_reg <= {txShift_reg[14:0], 1'b0};
      mdioOut_reg <= txShift_reg[15];
    end else if (mdcRise && state_reg != ST_TURN) begin
      mdioOut_reg <= 1'b1;
      mdioOeN_reg <= 1'b1;
    end
  end

  assign mdioOut = mdioOut_reg;
  assign mdioOeN = mdioOeN_reg;

  // register writes: only mapped writable bits are stored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      global_reg <= GLOBAL_RESET;
      prio01_reg <= PRIO_RESET;
      prio23_reg <= PRIO_RESET;
    end else if (commit && isGlobal) begin
      global_reg <= writeWord & GLOBAL_WR_MASK;
    end else if (commit && isPrio01) begin
      prio01_reg <= writeWord & PRIO_WR_MASK;
    end else if (commit && isPrio23) begin
      prio23_reg <= writeWord & PRIO_WR_MASK;
    end
  end

  // configuration source: the source bit itself always comes from the register, and the
  // register set, once selected, overrides the eeprom/strap words for every field
  wire        useRegs = global_reg[CFG_SRC];
  wire [15:0] effGlobal = useRegs ? global_reg : romWord12;
  wire [15:0] effPrio01 = useRegs ? prio01_reg : romWord13;
  wire [15:0] effPrio23 = useRegs ? prio23_reg : romWord14;

  wire [3:0] frameEnNext = {effPrio23[PRIO_B_FRAME], effPrio23[PRIO_A_FRAME],
                            effPrio01[PRIO_B_FRAME], effPrio01[PRIO_A_FRAME]};
  wire [3:0] portEnNext  = {effPrio23[PRIO_B_PORT], effPrio23[PRIO_A_PORT],
                            effPrio01[PRIO_B_PORT], effPrio01[PRIO_A_PORT]};

  wire fallbackNext = effGlobal[FALLBACK];
  wire agingNext    = effGlobal[AGING_EN];
  wire stormNext    = effGlobal[STORM_EN];
  wire bkpNext      = effGlobal[BKP_EN];
  wire [CNT_W-1:0] stormThr = CNT_W'(stormLimit(stormThresholdSel));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ledMode                 <= GLOBAL_RESET[LED_HI:LED_LO];
      pauseEnable             <= GLOBAL_RESET[PAUSE_EN];
      backpressureEnable      <= GLOBAL_RESET[BKP_EN];
      expansionPortFlowEnable <= GLOBAL_RESET[EXP_FLOW];
      configFromRegisters     <= GLOBAL_RESET[CFG_SRC];
      duplexFallbackEnable    <= GLOBAL_RESET[FALLBACK];
      agingEnable             <= GLOBAL_RESET[AGING_EN];
      framePriorityEn         <= 4'h0;
      portPriorityEn          <= 4'h0;
    end else begin
      ledMode                 <= effGlobal[LED_HI:LED_LO];
      pauseEnable             <= effGlobal[PAUSE_EN];
      backpressureEnable      <= bkpNext;
      expansionPortFlowEnable <= effGlobal[EXP_FLOW];
      configFromRegisters     <= useRegs;
      duplexFallbackEnable    <= fallbackNext;
      agingEnable             <= agingNext;
      framePriorityEn         <= frameEnNext;
      portPriorityEn          <= portEnNext;
    end
  end

  // per-packet and per-port decisions
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stormDrop         <= 1'b0;
      effFullDuplex     <= 5'h00;
      backpressureApply <= 5'h00;
      rxHighPriority    <= 4'h0;
    end else begin
      stormDrop         <= pktArrive & stormNext & (bcastQueueCount > stormThr);
      effFullDuplex     <= portFullDuplex & ~({5{fallbackNext}} & ~partnerPause);
      backpressureApply <= backpressureReq & ~effFullDuplex & {5{bkpNext}};
      rxHighPriority    <= portEnNext | (frameEnNext & rxTagHigh);
    end
  end

  // aging period timer; stopping it restarts the period so a re-enable waits a full 300 s
  logic [AGING_CNT_W-1:0] agingCnt_reg;
  wire                    agingWrap = (agingCnt_reg == AGING_LAST);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !agingNext) begin
      agingCnt_reg <= '0;
      agingTick    <= 1'b0;
    end else begin
      agingCnt_reg <= agingWrap ? '0 : AGING_CNT_W'(agingCnt_reg + 1'b1);
      agingTick    <= agingWrap;
    end
  end

endmodule
`default_nettype wire

// *** secr_pkg.sv ***
// constants, register layout and smi frame codes for the extended switch configuration bank
// assumes a single core clock domain; the smi pins are synchronised inside the register bank
package secr_pkg;

  localparam int REG_W = 16;

  // register addresses on the serial management interface
  localparam logic [4:0] REG_GLOBAL = 5'h12;
  localparam logic [4:0] REG_PRIO01 = 5'h13;
  localparam logic [4:0] REG_PRIO23 = 5'h14;

  // writable bits and reset values; bits outside the masks are not stored
  localparam logic [15:0] GLOBAL_WR_MASK = 16'hfcc8;
  localparam logic [15:0] GLOBAL_RESET   = 16'hf408;
  localparam logic [15:0] PRIO_WR_MASK   = 16'h6060;
  localparam logic [15:0] PRIO_RESET     = 16'h0000;

  // switch_global_control fields
  localparam int LED_HI    = 15;
  localparam int LED_LO    = 14;
  localparam int PAUSE_EN  = 13;
  localparam int BKP_EN    = 12;
  localparam int STORM_EN  = 11;
  localparam int EXP_FLOW  = 10;
  localparam int CFG_SRC   = 7;
  localparam int FALLBACK  = 6;
  localparam int AGING_EN  = 3;
  localparam int SPEED_ST  = 2;
  localparam int DUPLEX_ST = 1;

  // priority register fields: the upper pair is the even port, the lower pair the odd port
  localparam int PRIO_A_FRAME = 14;
  localparam int PRIO_A_PORT  = 13;
  localparam int PRIO_B_FRAME = 6;
  localparam int PRIO_B_PORT  = 5;

  // smi frame
  localparam logic [1:0] SMI_OP_READ   = 2'h2;
  localparam logic [1:0] SMI_OP_WRITE  = 2'h1;
  localparam logic [4:0] SMI_OP_LAST   = 5'h01;
  localparam logic [4:0] SMI_ADDR_LAST = 5'h09;
  localparam logic [4:0] SMI_TA_LAST   = 5'h01;
  localparam logic [4:0] SMI_DATA_LAST = 5'h0f;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_OP    = 6'h04,
    ST_ADDR  = 6'h08,
    ST_TURN  = 6'h10,
    ST_DATA  = 6'h20
  } secr_smi_state_e;

  // aging timer
  localparam longint CORE_CLK_HZ = 250_000_000;
  localparam longint AGING_TIME_S = 300;
  localparam longint AGING_CYCLES_DFLT = CORE_CLK_HZ * AGING_TIME_S;
  localparam int AGING_CNT_W = 37;

endpackage

// *** secr_pin_sync.sv ***
// two-flop synchronisers for the smi clock and data pins, with a rising-edge strobe for mdc
// assumes the pins are asynchronous to core_clk and that mdc is far slower than core_clk
`timescale 1ns/1ps
`default_nettype none
module secr_pin_sync (
  input  wire logic core_clk,   // core clock
  input  wire logic sys_rst,    // synchronous reset, active high
  input  wire logic mdcPin,     // management clock pin
  input  wire logic mdioPin,    // management data pin level
  output logic      mdcRise,    // one-cycle pulse on a synchronised mdc rising edge
  output logic      mdioSync    // synchronised mdio level
);
  logic mdcMeta_reg;
  logic mdcSync_reg;
  logic mdcLast_reg;
  logic mdioMeta_reg;
  logic mdioSync_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mdcMeta_reg  <= 1'b0;
      mdcSync_reg  <= 1'b0;
      mdcLast_reg  <= 1'b0;
      mdioMeta_reg <= 1'b1;
      mdioSync_reg <= 1'b1;
    end else begin
      mdcMeta_reg  <= mdcPin;
      mdcSync_reg  <= mdcMeta_reg;
      mdcLast_reg  <= mdcSync_reg;
      mdioMeta_reg <= mdioPin;
      mdioSync_reg <= mdioMeta_reg;
    end
  end

  // mdio passes the same depth as mdc, so the sample lines up with the edge
  assign mdcRise  = mdcSync_reg & ~mdcLast_reg;
  assign mdioSync = mdioSync_reg;
endmodule
`default_nettype wire

// *** secr_regs_sva.sv ***
// assertion checker for secr_regs, watching only its ports
// assumes one core clock domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module secr_regs_sva
  import secr_pkg::*;
#(
  parameter int         CNT_W        = 8,
  parameter longint     AGING_CYCLES = secr_pkg::AGING_CYCLES_DFLT,
  parameter logic [7:0] STORM_THR0   = 8'h08,
  parameter logic [7:0] STORM_THR1   = 8'h10,
  parameter logic [7:0] STORM_THR2   = 8'h20,
  parameter logic [7:0] STORM_THR3   = 8'h40
) (
  input wire logic             core_clk,                // core clock
  input wire logic             sys_rst,                 // synchronous reset
  input wire logic             mdioOeN,                 // mdio drive enable
  input wire logic [15:0]      romWord12,               // rom global word
  input wire logic [15:0]      romWord13,               // rom port 0/1 word
  input wire logic [15:0]      romWord14,               // rom port 2/3 word
  input wire logic [CNT_W-1:0] bcastQueueCount,         // queued broadcasts
  input wire logic [1:0]       stormThresholdSel,       // threshold choice
  input wire logic             pktArrive,               // arrival strobe
  input wire logic [4:0]       portFullDuplex,          // negotiated duplex
  input wire logic [4:0]       partnerPause,            // partner pause support
  input wire logic [4:0]       backpressureReq,         // congestion
  input wire logic [3:0]       rxTagHigh,               // tag says high
  input wire logic [1:0]       ledMode,                 // led mode
  input wire logic             pauseEnable,             // pause on
  input wire logic             backpressureEnable,      // backpressure on
  input wire logic             expansionPortFlowEnable, // expansion flow on
  input wire logic             configFromRegisters,     // register set used
  input wire logic             duplexFallbackEnable,    // fallback on
  input wire logic [4:0]       effFullDuplex,           // duplex after fallback
  input wire logic             agingEnable,             // aging on
  input wire logic             agingTick,               // aging period pulse
  input wire logic             stormDrop,               // drop pulse
  input wire logic [3:0]       framePriorityEn,         // frame priority
  input wire logic [3:0]       portPriorityEn,          // port priority
  input wire logic [3:0]       rxHighPriority,          // high queue
  input wire logic [4:0]       backpressureApply        // backpressure per port
);
  localparam int AGP = int'(AGING_CYCLES);
  localparam int AGM = AGP - 1;
  logic [31:0] agCnt;
  logic        tickSeen;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  function automatic logic [7:0] thr(input logic [1:0] s);
    return s == 2'h0 ? STORM_THR0 : s == 2'h1 ? STORM_THR1 : s == 2'h2 ? STORM_THR2 : STORM_THR3;
  endfunction
  // the first tick after enabling is not timed: only the spacing between ticks is
  always_ff @(posedge core_clk) begin
    agCnt <= (sys_rst || !agingEnable || agingTick) ? 32'h0 : agCnt + 32'h1;
  end
  always_ff @(posedge core_clk) begin
    tickSeen <= (sys_rst || !agingEnable) ? 1'b0 : (tickSeen || agingTick);
  end
  sequence s_drop_cause;
    $past(pktArrive) && ($past(bcastQueueCount) > thr($past(stormThresholdSel)));
  endsequence
  chk_reset_values: assert property (
    $past(sys_rst) |-> mdioOeN && ledMode == 2'h3 && pauseEnable && backpressureEnable
      && expansionPortFlowEnable && !configFromRegisters && !duplexFallbackEnable && agingEnable)
    else $error("outputs wrong after reset");
  chk_rom_select: assert property (
    !$past(sys_rst) && !configFromRegisters |->
      {ledMode, pauseEnable, backpressureEnable, expansionPortFlowEnable, duplexFallbackEnable,
       agingEnable, framePriorityEn} == $past({romWord12[15:12], romWord12[10], romWord12[6],
       romWord12[3], romWord14[6], romWord14[14], romWord13[6], romWord13[14]}))
    else $error("outputs do not follow rom words");
  chk_prio_map: assert property (
    !$past(sys_rst) && $stable(framePriorityEn) && $stable(portPriorityEn) |->
      rxHighPriority == (portPriorityEn | (framePriorityEn & $past(rxTagHigh))))
    else $error("priority decision wrong");
  chk_storm_cause: assert property (
    stormDrop |-> s_drop_cause)
    else $error("drop without arrival above threshold");
  chk_duplex_fall: assert property (
    !$past(sys_rst) && $stable(duplexFallbackEnable) |-> effFullDuplex ==
      ($past(portFullDuplex) & ~({5{duplexFallbackEnable}} & ~$past(partnerPause))))
    else $error("duplex fallback wrong");
  chk_bkp_apply: assert property (
    !$past(sys_rst) && $stable(backpressureEnable) |-> backpressureApply ==
      ($past(backpressureReq & ~effFullDuplex) & {5{backpressureEnable}}))
    else $error("backpressure applied wrongly");
  chk_aging_period: assert property (
    agingTick && tickSeen |-> agCnt == AGM)
    else $error("aging tick spacing wrong");
  chk_aging_late: assert property (
    tickSeen |-> agCnt <= AGP)
    else $error("aging tick missing");
  chk_aging_off: assert property (
    agingTick |-> agingEnable || $past(agingEnable))
    else $error("aging tick while disabled");
endmodule
bind secr_regs secr_regs_sva #(.CNT_W(CNT_W), .AGING_CYCLES(AGING_CYCLES),
  .STORM_THR0(STORM_THR0), .STORM_THR1(STORM_THR1), .STORM_THR2(STORM_THR2),
  .STORM_THR3(STORM_THR3)) chk (.*);
`default_nettype wire

// *** secr_smi_master.sv ***
// smi management master model: frames reads and writes on mdc and mdio
// assumes the bench resolves the mdio wire, with a pull-up, and feeds it back on mdioIn
`timescale 1ns/1ps
`default_nettype none
module secr_smi_master (
  input  wire logic core_clk, // core clock
  input  wire logic mdioIn,   // resolved mdio wire
  output var logic  mdcPin,   // smi clock, stands low between frames
  output var logic  mdioM     // master drive; 1 also stands for the released pull-up
);
  localparam int HALF = 10;   // mdc half period in core cycles, above the minimum of 8
  initial begin
    mdcPin = 1'b0;
    mdioM  = 1'b1;
  end
  // two preamble ones, start, op, phy, reg, turnaround, data; q keeps the last 16 samples
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] q, input logic [4:0] pa = 5'h00);
    logic [33:0] bits;
    bits = {4'b1101, rd ? 2'b10 : 2'b01, pa, ra, rd ? 18'h3ffff : {2'b10, wd}};
    q = 16'h0000;
    for (int i = 33; i >= 0; i--) begin
      @(negedge core_clk);
      mdcPin = 1'b0;
      mdioM  = bits[i];
      repeat (HALF) @(negedge core_clk);
      q = {q[14:0], mdioIn};
      mdcPin = 1'b1;
      repeat (HALF) @(negedge core_clk);
    end
    @(negedge core_clk);
    mdcPin = 1'b0;
    mdioM  = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** switch_extended_config_regs_test.sv ***
// self-checking bench for secr_regs: smi register traffic and random packet-side inputs
// assumes secr_smi_master as management master and secr_regs_sva bound to the design
`timescale 1ns/1ps
`default_nettype none
module switch_extended_config_regs_test;
  import secr_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, mdcPin, mdioM, mdioOut, mdioOeN, pktArrive = 1'b0;
  logic port4ExternalSelect = 1'b0, expansionSpeedIn = 1'b0, expansionDuplexIn = 1'b0;
  logic port4SpeedIn = 1'b0, port4DuplexIn = 1'b0;
  logic [15:0] romWord12 = 16'h0, romWord13 = 16'h0, romWord14 = 16'h0, q, w12, w13, w14, outs;
  logic [7:0]  bcastQueueCount = 8'h00;
  logic [1:0]  stormThresholdSel = 2'h0, ledMode;
  logic [4:0]  portFullDuplex = 5'h0, partnerPause = 5'h0, backpressureReq = 5'h0;
  logic [4:0]  backpressureApply, effFullDuplex;
  logic [3:0]  rxTagHigh = 4'h0, framePriorityEn, portPriorityEn, rxHighPriority;
  logic pauseEnable, backpressureEnable, expansionPortFlowEnable, configFromRegisters;
  logic duplexFallbackEnable, agingEnable, agingTick, stormDrop;
  logic [31:0] rnd, ra, rb;
  int seed = 32'ha0af527a, err_count = 0, check_count = 0;
  wire logic mdioIn;
  assign mdioIn = mdioOeN ? mdioM : mdioOut;
  assign outs = {ledMode, pauseEnable, backpressureEnable, expansionPortFlowEnable,
                 configFromRegisters, duplexFallbackEnable, agingEnable, framePriorityEn,
                 portPriorityEn};
  secr_regs #(.AGING_CYCLES(16)) DUT (.*);
  secr_smi_master smi (.core_clk(core_clk), .mdioIn(mdioIn), .mdcPin(mdcPin), .mdioM(mdioM));
  always #2 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    rnd = $random(seed);
    {rxTagHigh, portFullDuplex, partnerPause, backpressureReq} <= rnd[18:0];
    {bcastQueueCount, stormThresholdSel} <= rnd[28:19];
    pktArrive <= !pktArrive && rnd[29];
  end
  function automatic logic [15:0] exp12(input logic [15:0] w);
    logic s;
    logic d;
    s = port4ExternalSelect ? expansionSpeedIn : port4SpeedIn;
    d = port4ExternalSelect ? expansionDuplexIn : port4DuplexIn;
    return (w & GLOBAL_WR_MASK) | {13'h0000, s, d, 1'b0};
  endfunction
  function automatic logic [15:0] expOut(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] c);
    return {a[15:12], a[10], a[7], a[6], a[3], c[6], c[14], b[6], b[14], c[5], c[13], b[5], b[13]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // mdc low and mdio high for a few cycles after release before the first frame
  task automatic rstChk();
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge core_clk);
    smi.xfer(1'b1, REG_GLOBAL, 16'h0000, q);
    cmp(q, exp12(GLOBAL_RESET));
    smi.xfer(1'b1, REG_PRIO23, 16'h0000, q);
    cmp(q, PRIO_RESET);
  endtask
  initial begin
    rstChk();
    for (int i = 0; i < 6; i++) begin
      ra = $random(seed);
      rb = $random(seed);
      {w13, w12} = ra;
      w14 = rb[15:0];
      if (i < 2) begin
        w12 = {16{i == 0}};
        w13 = w12;
        w14 = w12;
      end
      // rom words differ from the registers in every stored bit other than the config source bit of word 12
      romWord12 = w12 ^ GLOBAL_WR_MASK;
      romWord13 = w13 ^ PRIO_WR_MASK;
      romWord14 = w14 ^ PRIO_WR_MASK;
      {port4ExternalSelect, expansionSpeedIn, expansionDuplexIn, port4SpeedIn} = rb[19:16];
      port4DuplexIn = rb[20];
      smi.xfer(1'b0, REG_PRIO01, w13, q);
      smi.xfer(1'b0, REG_PRIO23, w14, q);
      w12 = w12 | 16'h0080;
      smi.xfer(1'b0, REG_GLOBAL, w12, q);
      smi.xfer(1'b1, REG_GLOBAL, 16'h0000, q);
      cmp(q, exp12(w12));
      smi.xfer(1'b1, REG_PRIO01, 16'h0000, q);
      cmp(q, w13 & PRIO_WR_MASK);
      smi.xfer(1'b1, REG_PRIO23, 16'h0000, q);
      cmp(q, w14 & PRIO_WR_MASK);
      cmp(outs, expOut(w12, w13, w14));
    end
    smi.xfer(1'b0, 5'h15, 16'h0000, q);
    smi.xfer(1'b1, 5'h15, 16'h0000, q);
    cmp(q, 16'hffff);
    // a foreign device address must neither be answered nor change the bank
    smi.xfer(1'b0, REG_GLOBAL, 16'h0000, q, 5'h01);
    smi.xfer(1'b1, REG_GLOBAL, 16'h0000, q, 5'h01);
    cmp(q, 16'hffff);
    smi.xfer(1'b1, REG_GLOBAL, 16'h0000, q);
    cmp(q, exp12(w12));
    rstChk();
    results();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
